// >>> shared/dcs_pkg.sv
// constants, command codes and state types for the dram command-state pair
// assumes one 20 MHz clock shared by controller end and device end
// Functional notes
// - device compares current and previous clock enable
// - state before edge picks power-down kind
// - only nop/deselect on power-down enter/exit
// - self-refresh only from idle via refresh
// - self-refresh exit with nop, cke high
// - nop/deselect only during non-read exit delay
// - no read before 200 clocks after exit
// - cke high both edges: legal commands only
// - unlisted combinations illegal, never generated
// - no low-power entry during busy operations
// - hold cke three edges after transition
// - odt ignored for transitions, off in self-refresh
// - no refresh in power-down, controller bounds it; dcs_ctrl sets no limit and keeps cke low while i_cke and i_ocd_cal are low
// - cke high during impedance calibration
// - odt driven valid in power-down if enabled
// - data mask high inhibits write beat
// - idle state command responses
// - banks-active state command responses
// - burst continue, same-type interrupt, else illegal
// - command decoded from strobes at edge
// - no interrupt of length-four bursts
// - wait exit latency after power-down exit
package dcs_pkg;
   // {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      DCS_CMD_MRS = 4'h0,
      DCS_CMD_REF = 4'h1,
      DCS_CMD_PRE = 4'h2,
      DCS_CMD_ACT = 4'h3,
      DCS_CMD_WR = 4'h4,
      DCS_CMD_RD = 4'h5,
      DCS_CMD_NOP = 4'h7,
      DCS_CMD_DSL = 4'h8
   } dcs_cmd_t;
   typedef enum logic [2:0] {
      DCS_ST_IDLE,
      DCS_ST_ACTIVE,
      DCS_ST_READ,
      DCS_ST_WRITE,
      DCS_ST_APD,
      DCS_ST_PPD,
      DCS_ST_SREF
   } dcs_state_t;
   localparam int DCS_NBANK = 4;
   localparam int DCS_CKE_MIN_CLK = 3;
   localparam int DCS_XSRD_CLK = 200;
   localparam int DCS_XSNR_CLK = 10;
   localparam int DCS_XP_CLK = 2;
   localparam int DCS_BURST_LEN = 4;
   localparam logic [7:0] DCS_XSRD_CNT = 8'(DCS_XSRD_CLK);
   localparam logic [7:0] DCS_XSNR_CNT = 8'(DCS_XSNR_CLK);
   localparam logic [7:0] DCS_XP_CNT = 8'(DCS_XP_CLK);
   localparam logic [1:0] DCS_CKE_HOLD = 2'(DCS_CKE_MIN_CLK - 1);
   localparam logic [2:0] DCS_BURST_CNT = 3'(DCS_BURST_LEN / 2);
endpackage : dcs_pkg

// >>> shared/dcs_if.sv
// command/clock-enable link between controller end and device end
// assumes both ends clocked by the same i_clk_sys
`timescale 1ns/1ps
`default_nettype none
interface dcs_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] ba;
   logic a10;
   logic odt;
   logic dm;
   logic wvalid;
   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, a10, odt, dm, wvalid);
   modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, a10, odt, dm, wvalid);
endinterface : dcs_if
`default_nettype wire

// >>> design/dcs_cnt.sv
// small down-counter used for delay windows by the controller end
// assumes synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module dcs_cnt #(
   parameter int W = 8
) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_load,
   input wire logic [W-1:0] i_val,
   output logic o_busy
);
   logic [W-1:0] cnt_reg;
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         cnt_reg <= '0;
      end else if (i_load) begin
         cnt_reg <= i_val;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end
   assign o_busy = (cnt_reg != '0);
endmodule : dcs_cnt
`default_nettype wire

// >>> design/dcs_dev.sv
// device end: tracks cke history, bank and burst state, flags illegal commands
// assumes controller drives link synchronously to i_clk_sys
`timescale 1ns/1ps
`default_nettype none
module dcs_dev (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   dcs_if.dev link,
   output dcs_pkg::dcs_state_t o_state,
   output logic [3:0] o_open_banks,
   output logic o_illegal,
   output logic o_wr_beat,
   output logic o_odt_on,
   output logic o_refresh
);
   import dcs_pkg::*;
   dcs_state_t state_reg;
   logic cke_prev_reg;
   logic [3:0] open_reg;
   logic [2:0] burst_reg;
   logic illegal_reg;
   logic wr_beat_reg;
   logic odt_reg;
   logic ref_reg;
   dcs_cmd_t cmd;
   logic is_nop;
   logic illegal;
   dcs_state_t state_next;
   logic [3:0] open_next;
   logic [2:0] burst_next;

   always_comb begin
      cmd = link.cs_n ? DCS_CMD_DSL : dcs_cmd_t'({1'b0, link.ras_n, link.cas_n, link.we_n});
   end
   assign is_nop = (cmd == DCS_CMD_DSL) || (cmd == DCS_CMD_NOP);

   always_comb begin
      state_next = state_reg;
      open_next = open_reg;
      burst_next = (burst_reg != 3'h0) ? burst_reg - 3'h1 : 3'h0;
      illegal = 1'b0;
      if (!cke_prev_reg) begin
         if (link.cke) begin
            if (!is_nop) begin
               illegal = 1'b1;
            end else if (state_reg == DCS_ST_APD) begin
               state_next = DCS_ST_ACTIVE;
            end else begin
               state_next = (state_reg == DCS_ST_SREF || state_reg == DCS_ST_PPD)
                  ? DCS_ST_IDLE : state_reg;
            end
         end
      end else if (!link.cke) begin
         if (is_nop && (state_reg == DCS_ST_IDLE || state_reg == DCS_ST_ACTIVE)) begin
            state_next = (open_reg != 4'h0) ? DCS_ST_APD : DCS_ST_PPD;
         end else if (cmd == DCS_CMD_REF && state_reg == DCS_ST_IDLE) begin
            state_next = DCS_ST_SREF;
         end else begin
            illegal = 1'b1;
         end
      end else begin
         unique case (state_reg)
            DCS_ST_IDLE: begin
               if (cmd == DCS_CMD_ACT) begin
                  open_next = open_reg | (4'h1 << link.ba);
                  state_next = DCS_ST_ACTIVE;
               end else if (cmd == DCS_CMD_RD || cmd == DCS_CMD_WR) begin
                  illegal = 1'b1;
               end
            end
            DCS_ST_ACTIVE: begin
               if (cmd == DCS_CMD_RD || cmd == DCS_CMD_WR) begin
                  state_next = (cmd == DCS_CMD_RD) ? DCS_ST_READ : DCS_ST_WRITE;
                  burst_next = DCS_BURST_CNT;
               end else if (cmd == DCS_CMD_PRE) begin
                  open_next = link.a10 ? 4'h0 : (open_reg & ~(4'h1 << link.ba));
                  state_next = (open_next == 4'h0) ? DCS_ST_IDLE : DCS_ST_ACTIVE;
               end else if (!is_nop) begin
                  illegal = 1'b1;
               end
            end
            DCS_ST_READ, DCS_ST_WRITE: begin
               if ((state_reg == DCS_ST_READ && cmd == DCS_CMD_RD) ||
                   (state_reg == DCS_ST_WRITE && cmd == DCS_CMD_WR)) begin
                  burst_next = DCS_BURST_CNT;
               end else if (!is_nop) begin
                  illegal = 1'b1;
               end else if (burst_reg <= 3'h1) begin
                  state_next = DCS_ST_ACTIVE;
               end
            end
            default: illegal = 1'b1;
         endcase
      end
      if (illegal) begin
         state_next = state_reg;
         open_next = open_reg;
         burst_next = burst_reg;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         state_reg <= DCS_ST_IDLE;
         open_reg <= 4'h0;
         burst_reg <= 3'h0;
         cke_prev_reg <= 1'b0;
         illegal_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         open_reg <= open_next;
         burst_reg <= burst_next;
         cke_prev_reg <= link.cke;
         illegal_reg <= illegal;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         wr_beat_reg <= 1'b0;
      end else begin
         wr_beat_reg <= (state_reg == DCS_ST_WRITE) && link.wvalid && !link.dm;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         odt_reg <= 1'b0;
      end else begin
         odt_reg <= link.odt && (state_next != DCS_ST_SREF);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         ref_reg <= 1'b0;
      end else begin
         // self-refresh entry is not an auto refresh
         ref_reg <= !illegal && cke_prev_reg && link.cke && (cmd == DCS_CMD_REF)
            && (state_reg == DCS_ST_IDLE);
      end
   end

   assign o_state = state_reg;
   assign o_open_banks = open_reg;
   assign o_illegal = illegal_reg;
   assign o_wr_beat = wr_beat_reg;
   assign o_odt_on = odt_reg;
   assign o_refresh = ref_reg;
endmodule : dcs_dev
`default_nettype wire

// >>> design/dcs_ctrl.sv
// controller end: issues one user request at a time, guarding cke and delay windows
// assumes user holds request until accepted
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_req,
   input wire dcs_pkg::dcs_cmd_t i_cmd,
   input wire logic [1:0] i_ba,
   input wire logic i_a10,
   input wire logic i_cke,
   input wire logic i_odt,
   input wire logic i_dm,
   input wire logic i_wvalid,
   input wire logic i_ocd_cal,
   output logic o_ack,
   dcs_if.ctrl link
);
   import dcs_pkg::*;
   logic cke_reg;
   logic [1:0] hold_reg;
   logic sref_reg;
   logic [2:0] burst_reg;
   dcs_cmd_t cmd_reg;
   logic [1:0] ba_reg;
   logic a10_reg;
   logic odt_reg;
   logic dm_reg;
   logic wv_reg;
   logic xsnr_busy;
   logic xsrd_busy;
   logic xp_busy;
   logic cke_want;
   logic cke_change;
   logic cmd_ok;
   logic sref_exit;
   logic sref_enter;

   assign cke_want = i_ocd_cal | i_cke;
   // refresh request rides the cke fall
   assign sref_enter = cke_reg && !cke_want && i_req && (i_cmd == DCS_CMD_REF)
      && (hold_reg == 2'h0) && (burst_reg == 3'h0) && !xsnr_busy && !xp_busy;
   // three-edge hold; no entry while busy
   assign cke_change = (cke_want != cke_reg) && (hold_reg == 2'h0)
      && (burst_reg == 3'h0) && (!(cke_reg && i_req) || sref_enter);
   assign sref_exit = cke_change && !cke_reg && sref_reg;

   always_comb begin
      // self-refresh entry is the one command taken on a cke change
      cmd_ok = cke_reg && (!cke_change || sref_enter) && !xsnr_busy && !xp_busy;
      if (i_cmd == DCS_CMD_RD && xsrd_busy) begin
         cmd_ok = 1'b0;
      end
      if (burst_reg != 3'h0 && i_cmd != DCS_CMD_NOP && i_cmd != DCS_CMD_DSL) begin
         cmd_ok = 1'b0;
      end
   end
   assign o_ack = i_req && cmd_ok;

   dcs_cnt #(.W(8)) u_xsnr (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_load(sref_exit),
      .i_val(DCS_XSNR_CNT),
      .o_busy(xsnr_busy)
   );
   dcs_cnt #(.W(8)) u_xsrd (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_load(sref_exit),
      .i_val(DCS_XSRD_CNT),
      .o_busy(xsrd_busy)
   );
   dcs_cnt #(.W(8)) u_xp (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_load(cke_change && !cke_reg && !sref_reg),
      .i_val(DCS_XP_CNT),
      .o_busy(xp_busy)
   );

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         cke_reg <= 1'b0;
         hold_reg <= 2'h0;
         sref_reg <= 1'b0;
      end else if (cke_change) begin
         cke_reg <= cke_want;
         hold_reg <= DCS_CKE_HOLD;
         // refresh on falling edge enters self-refresh
         sref_reg <= cke_reg && (i_cmd == DCS_CMD_REF) && i_req;
      end else if (hold_reg != 2'h0) begin
         hold_reg <= hold_reg - 2'h1;
      end
   end

   // only accepted commands leave, else nop
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         cmd_reg <= DCS_CMD_DSL;
         ba_reg <= 2'h0;
         a10_reg <= 1'b0;
         burst_reg <= 3'h0;
      end else begin
         cmd_reg <= o_ack ? i_cmd : DCS_CMD_NOP;
         ba_reg <= i_ba;
         a10_reg <= i_a10;
         // precharge and mode set also hold off a cke fall
         if (o_ack && (i_cmd == DCS_CMD_RD || i_cmd == DCS_CMD_WR || i_cmd == DCS_CMD_PRE
               || i_cmd == DCS_CMD_MRS)) begin
            burst_reg <= DCS_BURST_CNT;
         end else if (burst_reg != 3'h0) begin
            burst_reg <= burst_reg - 3'h1;
         end
      end
   end

   // odt valid level; mask with beat
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         odt_reg <= 1'b0;
         dm_reg <= 1'b1;
         wv_reg <= 1'b0;
      end else begin
         odt_reg <= i_odt;
         dm_reg <= i_dm;
         wv_reg <= i_wvalid;
      end
   end

   assign link.cke = cke_reg;
   assign link.cs_n = cmd_reg[3];
   assign link.ras_n = cmd_reg[2];
   assign link.cas_n = cmd_reg[1];
   assign link.we_n = cmd_reg[0];
   assign link.ba = ba_reg;
   assign link.a10 = a10_reg;
   assign link.odt = odt_reg;
   assign link.dm = dm_reg;
   assign link.wvalid = wv_reg;
endmodule : dcs_ctrl
`default_nettype wire

// >>> verification/dcs_props.sv
// checker for the command and clock-enable wires between the two ends
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module dcs_props (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n
);
   import dcs_pkg::*;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   logic [3:0] cmd;
   logic nop, busy, sref_reg;
   logic [7:0] xsnr_reg, xsrd_reg;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign nop = cs_n | (cmd == DCS_CMD_NOP);
   assign busy = (cmd == DCS_CMD_RD) | (cmd == DCS_CMD_WR) | (cmd == DCS_CMD_MRS)
      | (cmd == DCS_CMD_PRE);
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         sref_reg <= 1'b0;
      end else if ($fell(cke)) begin
         sref_reg <= (cmd == DCS_CMD_REF);
      end
   end
   // exit windows counted from the edge that registers cke high
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         xsnr_reg <= 8'h00;
         xsrd_reg <= 8'h00;
      end else if ($rose(cke) && sref_reg) begin
         xsnr_reg <= DCS_XSNR_CNT - 8'h01;
         xsrd_reg <= DCS_XSRD_CNT - 8'h01;
      end else begin
         xsnr_reg <= (xsnr_reg != 8'h00) ? xsnr_reg - 8'h01 : 8'h00;
         xsrd_reg <= (xsrd_reg != 8'h00) ? xsrd_reg - 8'h01 : 8'h00;
      end
   end
   sequence s_quiet;
      nop && cke;
   endsequence
   sequence s_hold;
      $stable(cke) [*2];
   endsequence
   a_cke_min_hold: assert property ($changed(cke) |=> s_hold)
      else $error("cke changed within three edges");
   a_pd_enter_nop: assert property ($fell(cke) |-> nop || cmd == DCS_CMD_REF)
      else $error("command on cke fall");
   a_exit_nop: assert property ($rose(cke) |-> nop)
      else $error("command on cke rise");
   a_exit_latency: assert property ($rose(cke) |=> nop [*2])
      else $error("command too soon after exit");
   a_sref_quiet: assert property (xsnr_reg != 8'h00 |-> nop)
      else $error("command inside exit window");
   a_sref_no_read: assert property (xsrd_reg != 8'h00 |-> cmd != DCS_CMD_RD)
      else $error("read inside read exit window");
   a_burst_whole: assert property (cmd == DCS_CMD_RD || cmd == DCS_CMD_WR |=> s_quiet)
      else $error("burst interrupted");
   a_busy_no_pd: assert property (busy |=> cke ##1 cke)
      else $error("low power entry while busy");
   a_cmd_legal: assert property (cke && $past(cke) |-> cs_n || cmd != 4'h6)
      else $error("reserved command code");
endmodule : dcs_props
`default_nettype wire

// >>> verification/testbench.sv
// bench: controller end drives device end; checks device state outputs
// assumes 20 MHz clock and a 16-cycle synchronous reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dcs_pkg::*;
   logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_req = 1'b0, i_a10 = 1'b0, i_cke = 1'b1;
   logic i_odt = 1'b0, i_dm = 1'b1, i_wvalid = 1'b0, i_ocd_cal = 1'b0;
   dcs_cmd_t i_cmd = DCS_CMD_NOP;
   logic [1:0] i_ba = 2'h0;
   logic o_ack, o_illegal, o_wr_beat, o_odt_on, o_refresh;
   dcs_state_t o_state;
   logic [3:0] o_open_banks;
   int n_fail = 0, tests_run = 0, cyc = 0, beats = 0, t0 = 0, refs = 0;
   dcs_if link();
   always #25 i_clk_sys = ~i_clk_sys;
   dcs_ctrl dcs_ctrl_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req(i_req), .i_cmd(i_cmd),
      .i_ba(i_ba), .i_a10(i_a10), .i_cke(i_cke), .i_odt(i_odt), .i_dm(i_dm),
      .i_wvalid(i_wvalid), .i_ocd_cal(i_ocd_cal), .o_ack(o_ack), .link(link));
   dcs_dev dcs_dev_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .link(link), .o_state(o_state),
      .o_open_banks(o_open_banks), .o_illegal(o_illegal), .o_wr_beat(o_wr_beat),
      .o_odt_on(o_odt_on), .o_refresh(o_refresh));
   dcs_props dcs_props_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .cke(link.cke),
      .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // ack is combinational, so it is read at the falling edge before the taking edge
   task automatic cmd(input dcs_cmd_t c, input logic [1:0] b, input logic a,
      input dcs_state_t es, input logic [3:0] eb, input logic ei);
      logic got;
      int k;
      k = 0;
      i_req <= 1'b1;
      i_cmd <= c;
      i_ba <= b;
      i_a10 <= a;
      do begin
         @(negedge i_clk_sys);
         got = o_ack;
         k++;
         @(posedge i_clk_sys);
      end while (got !== 1'b1 && k < 400);
      i_req <= 1'b0;
      @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      chk({7'h00, got}, 8'h01);
      chk(8'(o_state), 8'(es));
      chk({4'h0, o_open_banks}, {4'h0, eb});
      chk({7'h00, o_illegal}, {7'h00, ei});
      @(posedge i_clk_sys);
   endtask : cmd
   task automatic expect_state(input int n, input dcs_state_t es, input logic eo);
      repeat (n) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      chk(8'(o_state), 8'(es));
      chk({7'h00, o_odt_on}, {7'h00, eo});
      @(posedge i_clk_sys);
   endtask : expect_state
   always @(posedge i_clk_sys) begin
      cyc++;
      if (o_wr_beat === 1'b1) beats++;
      if (o_refresh === 1'b1) refs++;
      if (cyc == 3000) begin
         n_fail++;
         complete_run();
      end
   end
   initial begin
      repeat (16) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      cmd(DCS_CMD_RD, 2'h0, 1'b0, DCS_ST_IDLE, 4'h0, 1'b1);
      cmd(DCS_CMD_WR, 2'h0, 1'b0, DCS_ST_IDLE, 4'h0, 1'b1);
      cmd(DCS_CMD_REF, 2'h0, 1'b0, DCS_ST_IDLE, 4'h0, 1'b0);
      cmd(DCS_CMD_MRS, 2'h0, 1'b0, DCS_ST_IDLE, 4'h0, 1'b0);
      chk(8'(refs), 8'h01);
      cmd(DCS_CMD_ACT, 2'h2, 1'b0, DCS_ST_ACTIVE, 4'h4, 1'b0);
      cmd(DCS_CMD_ACT, 2'h1, 1'b0, DCS_ST_ACTIVE, 4'h4, 1'b1);
      cmd(DCS_CMD_REF, 2'h0, 1'b0, DCS_ST_ACTIVE, 4'h4, 1'b1);
      cmd(DCS_CMD_MRS, 2'h0, 1'b0, DCS_ST_ACTIVE, 4'h4, 1'b1);
      cmd(DCS_CMD_RD, 2'h2, 1'b0, DCS_ST_READ, 4'h4, 1'b0);
      i_dm <= 1'b0;
      i_wvalid <= 1'b1;
      beats = 0;
      cmd(DCS_CMD_WR, 2'h2, 1'b0, DCS_ST_WRITE, 4'h4, 1'b0);
      expect_state(4, DCS_ST_ACTIVE, 1'b0);
      chk(8'(beats != 0), 8'h01);
      i_dm <= 1'b1;
      beats = 0;
      cmd(DCS_CMD_WR, 2'h2, 1'b0, DCS_ST_WRITE, 4'h4, 1'b0);
      expect_state(4, DCS_ST_ACTIVE, 1'b0);
      chk(8'(beats), 8'h00);
      i_wvalid <= 1'b0;
      cmd(DCS_CMD_PRE, 2'h0, 1'b1, DCS_ST_IDLE, 4'h0, 1'b0);
      cmd(DCS_CMD_ACT, 2'h1, 1'b0, DCS_ST_ACTIVE, 4'h2, 1'b0);
      i_cke <= 1'b0;
      expect_state(8, DCS_ST_APD, 1'b0);
      i_cke <= 1'b1;
      expect_state(8, DCS_ST_ACTIVE, 1'b0);
      cmd(DCS_CMD_PRE, 2'h0, 1'b1, DCS_ST_IDLE, 4'h0, 1'b0);
      i_odt <= 1'b1;
      i_ocd_cal <= 1'b1;
      i_cke <= 1'b0;
      expect_state(8, DCS_ST_IDLE, 1'b1);
      i_ocd_cal <= 1'b0;
      expect_state(8, DCS_ST_PPD, 1'b1);
      i_cke <= 1'b1;
      expect_state(8, DCS_ST_IDLE, 1'b1);
      i_cke <= 1'b0;
      cmd(DCS_CMD_REF, 2'h0, 1'b0, DCS_ST_SREF, 4'h0, 1'b0);
      expect_state(6, DCS_ST_SREF, 1'b0);
      i_cke <= 1'b1;
      t0 = cyc;
      cmd(DCS_CMD_ACT, 2'h0, 1'b0, DCS_ST_ACTIVE, 4'h1, 1'b0);
      chk(8'(cyc - t0 >= DCS_XSNR_CLK), 8'h01);
      cmd(DCS_CMD_RD, 2'h0, 1'b0, DCS_ST_READ, 4'h1, 1'b0);
      chk(8'(cyc - t0 > DCS_XSRD_CLK), 8'h01);
      expect_state(4, DCS_ST_ACTIVE, 1'b1);
      chk(8'(refs), 8'h01);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
